// *** hdl/ac_presence_defines.svh ***
// Purpose: Timing and count constants for the mains presence judge
// Assumes: 25 MHz system clock, 1 MHz oscillator tick derived from it
// Notes:   Times are kept in their own unit; cycle counts derive from them
`ifndef AC_PRESENCE_DEFINES_SVH
`define AC_PRESENCE_DEFINES_SVH

// ****************************************
// Clock and tick rates
// ****************************************
`define SYS_CLK_HZ        25000000
`define OSC_HZ            1000000
`define OSC_DIV           (`SYS_CLK_HZ / `OSC_HZ)
`define STATE_TICK_HZ     7800
// State tick: divide oscillator to 7.8 kHz (128 oscillator periods)
`define STATE_DIV         (`OSC_HZ / `STATE_TICK_HZ)
`define FILT_FAST_US      4
`define FILT_SLOW_US      1000
`define FILT_SAMPLES      3

// ****************************************
// Timed windows in ms, ticks rounded up
// ****************************************
`define INIT_WIN_MS       12
`define SETTLE_MIN_MS     12
`define SETTLE_MAX_MS     25
`define TROUGH_WIN_MS     8
`define MS_TO_TICKS(ms)   (((ms) * `STATE_TICK_HZ + 999) / 1000)

`endif

// *** hdl/ac_presence_pkg.sv ***
// Purpose: Types for the mains presence judge
// Assumes: Included defines provide all figures
// Notes:   Holds the state encoding and flag bundle
package ac_presence_pkg;

  // Judge states with fixed binary codes
  typedef enum logic [2:0] {
    ST_RESET  = 3'h0,
    ST_INIT   = 3'h1,
    ST_SETTLE = 3'h2,
    ST_CREST  = 3'h3,
    ST_TROUGH = 3'h4,
    ST_LOW    = 3'h5,
    ST_FAULT  = 3'h6
  } judge_state_t;

  // Filtered comparator flags travelling together
  typedef struct packed {
    logic above_65pct_flag;
    logic peak_level_ok;
  } sense_flags_t;

endpackage

// *** hdl/tick_divider.sv ***
// Purpose: Produce a one-cycle tick every DIV input strobes
// Assumes: strobe_in is a one-cycle pulse
// Notes:   DIV of 1 passes each strobe through, registered one cycle late
`timescale 1ns/100ps
module tick_divider #(
  parameter int DIV = 25
) (
  // Clock and reset
  input  wire logic sys_clk_in,
  input  wire logic rst_in,
  // Strobe in, tick out
  input  wire logic strobe_in,
  output logic      tick_out
);

  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic          next_tick;

  initial begin
    if (DIV < 1) $error("tick_divider DIV must be at least 1");
  end

  // Count strobes and wrap at DIV
  always_comb begin
    next_count = count;
    next_tick  = 1'b0;
    if (strobe_in) begin
      if (count == CW'(DIV - 1)) begin
        next_count = '0;
        next_tick  = 1'b1;
      end else begin
        next_count = count + CW'(1);
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      count    <= '0;
      tick_out <= 1'b0;
    end else begin
      count    <= next_count;
      tick_out <= next_tick;
    end
  end

endmodule

// *** hdl/chatter_filter.sv ***
// Purpose: Accept a new input level only after N agreeing samples
// Assumes: sample_in pulses once per filter period
// Notes:   Output holds its level until the run completes
`timescale 1ns/100ps
`include "ac_presence_defines.svh"
module chatter_filter #(
  parameter int SAMPLES = `FILT_SAMPLES,
  parameter bit INIT    = 1'b0
) (
  // Clock and reset
  input  wire logic sys_clk_in,
  input  wire logic rst_in,
  // Raw level and sampling strobe
  input  wire logic raw_in,
  input  wire logic sample_in,
  // Filtered level
  output logic      level_out
);

  localparam int CW = $clog2(SAMPLES + 1);

  logic [CW-1:0] run;
  logic [CW-1:0] next_run;
  logic          next_level;

  initial begin
    if (SAMPLES < 1) $error("chatter_filter SAMPLES must be at least 1");
  end

  // Count consecutive samples that differ from the held level
  always_comb begin
    next_run   = run;
    next_level = level_out;
    if (sample_in) begin
      if (raw_in == level_out) begin
        next_run = '0;
      end else if (run == CW'(SAMPLES - 1)) begin
        next_run   = '0;
        next_level = raw_in;
      end else begin
        next_run = run + CW'(1);
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      run       <= '0;
      level_out <= INIT;
    end else begin
      run       <= next_run;
      level_out <= next_level;
    end
  end

endmodule

// *** hdl/ac_input_presence_fsm.sv ***
// Purpose: Judge whether rectified mains is present and healthy
// Assumes: Comparator flags are synchronous to sys_clk_in
// Notes:   State changes advance on a 7.8 kHz tick from a 1 MHz divider, except the forced reset
// How it works
// [R1] After reset enter init; mains good stays low in reset and init.
// [R2] In init, peak level ok moves to settle.
// [R3] No peak level ok within 12 ms of init gives low level state.
// [R4] After 12 ms in settle, above 65 percent moves to crest, output high.
// [R5] In low level state, peak level ok moves to settle.
// [R6] In settle, losing peak level ok goes to low level, output low.
// [R7] No crest within 25 ms of settle entry gives fault state.
// [R8] Trough returns to crest on above 65 percent within 8 ms, else fault.
// [R9] Crest moves to trough when above 65 percent clears; never faults there.
// [R10] Mains off judged only at trough, settle or init timeout, or after peak level ok is lost.
// [R11] In fault, above 65 percent with peak level ok returns to crest.
// [R12] In fault, losing peak level ok goes to low level state.
// [R13] Trough timeout into fault raises discharge until flag sets or peak lost.
// [R14] State logic advances on a 7.8 kHz tick divided from the oscillator.
// [R15] Flags and reset pass a three-sample chatter filter.
// [R16] Output cannot rise until slow-filtered peak level ok is confirmed.
// [R17] Each timed window counts ticks and restarts on state entry.
// [R18] Mains good and discharge are registered; mains good is decoded from state, discharge from its own latch.
`timescale 1ns/100ps
`include "ac_presence_defines.svh"
module ac_input_presence_fsm
  import ac_presence_pkg::*;
#(
  parameter int INIT_TICKS   = `MS_TO_TICKS(`INIT_WIN_MS),
  parameter int SETTLE_MIN   = `MS_TO_TICKS(`SETTLE_MIN_MS),
  parameter int SETTLE_MAX   = `MS_TO_TICKS(`SETTLE_MAX_MS),
  parameter int TROUGH_TICKS = `MS_TO_TICKS(`TROUGH_WIN_MS)
) (
  // Clock and reset
  input  wire logic sys_clk_in,
  input  wire logic rst_in,
  // Raw comparator flags
  input  wire logic above_65pct_in,
  input  wire logic peak_level_ok_in,
  // Judgement outputs
  output logic      mains_good_out,
  output logic      discharge_req_out
);

  // ****************************************
  // Tick generation
  // ****************************************
  localparam int TW = 9;

  logic osc_tick;
  logic fast_tick;
  logic slow_tick;
  logic state_tick;

  initial begin
    if (SETTLE_MIN >= SETTLE_MAX) $error("settle window minimum must be below maximum");
    if (INIT_TICKS < 1 || TROUGH_TICKS < 1) $error("timed windows must be at least one tick");
    if (SETTLE_MAX >= (1 << TW)) $error("timer too narrow for windows");
  end

  // 1 MHz oscillator tick from the 25 MHz clock
  tick_divider #(.DIV(`OSC_DIV)) u_osc_div (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .strobe_in  (1'b1),
    .tick_out   (osc_tick)
  );

  // Fast filter tick for comparator and reset filters
  tick_divider #(.DIV(`FILT_FAST_US)) u_fast_div (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .strobe_in  (osc_tick),
    .tick_out   (fast_tick)
  );

  // Millisecond tick for the start-up confirmation
  tick_divider #(.DIV(`FILT_SLOW_US)) u_slow_div (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .strobe_in  (osc_tick),
    .tick_out   (slow_tick)
  );

  // State logic tick, 7.8 kHz; see [R14]
  tick_divider #(.DIV(`STATE_DIV)) u_state_div (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .strobe_in  (osc_tick),
    .tick_out   (state_tick)
  );

  // ****************************************
  // Chatter filters
  // ****************************************
  sense_flags_t flags;
  logic         peak_confirmed;
  logic         hold_reset;

  // Comparator flags filtered at the fast tick; see [R15]
  chatter_filter u_f65 (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .raw_in     (above_65pct_in),
    .sample_in  (fast_tick),
    .level_out  (flags.above_65pct_flag)
  );

  chatter_filter u_fok (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .raw_in     (peak_level_ok_in),
    .sample_in  (fast_tick),
    .level_out  (flags.peak_level_ok)
  );

  // Reset release filtered too, so a glitchy reset cannot start judging; see [R15]
  chatter_filter #(.INIT(1'b1)) u_frst (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .raw_in     (1'b0),
    .sample_in  (fast_tick),
    .level_out  (hold_reset)
  );

  // Slow confirmation of held peak gates first rise of the output; see [R16]
  chatter_filter u_fconf (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .raw_in     (peak_level_ok_in),
    .sample_in  (slow_tick),
    .level_out  (peak_confirmed)
  );

  // ****************************************
  // Judge state machine
  // ****************************************
  judge_state_t state;
  judge_state_t next_state;
  logic [TW-1:0] timer;
  logic [TW-1:0] next_timer;
  logic          started;
  logic          next_started;
  logic          discharge;
  logic          next_discharge;
  logic          next_good;

  // Decide the next state on each state tick only, or force reset at once while hold_reset is high; see [R14]
  always_comb begin
    next_state = state;
    if (hold_reset) begin
      next_state = ST_RESET;
    end else if (state_tick) begin
      unique case (state)
        ST_RESET: begin
          next_state = ST_INIT; // see [R1]
        end
        ST_INIT: begin
          if (flags.peak_level_ok) begin
            next_state = ST_SETTLE; // see [R2]
          end else if (timer >= TW'(INIT_TICKS - 1)) begin
            next_state = ST_LOW; // see [R3]
          end
        end
        ST_SETTLE: begin
          if (!flags.peak_level_ok) begin
            next_state = ST_LOW; // see [R6] [R10]
          end else if (timer >= TW'(SETTLE_MIN) && flags.above_65pct_flag) begin
            next_state = ST_CREST; // see [R4]
          end else if (timer >= TW'(SETTLE_MAX - 1)) begin
            next_state = ST_FAULT; // see [R7]
          end
        end
        ST_CREST: begin
          // No timeout here: mains off is never judged at the crest; see [R9] [R10]
          if (!flags.above_65pct_flag) begin
            next_state = ST_TROUGH;
          end
        end
        ST_TROUGH: begin
          if (flags.above_65pct_flag) begin
            next_state = ST_CREST; // see [R8]
          end else if (timer >= TW'(TROUGH_TICKS - 1)) begin
            next_state = ST_FAULT; // see [R8] [R10]
          end
        end
        ST_LOW: begin
          if (flags.peak_level_ok) begin
            next_state = ST_SETTLE; // see [R5]
          end
        end
        ST_FAULT: begin
          if (!flags.peak_level_ok) begin
            next_state = ST_LOW; // see [R12]
          end else if (flags.above_65pct_flag) begin
            next_state = ST_CREST; // see [R11]
          end
        end
        default: begin
          next_state = ST_RESET;
        end
      endcase
    end
  end

  // Window timer restarts on every state change; see [R17]
  always_comb begin
    next_timer = timer;
    if (next_state != state) begin
      next_timer = '0;
    end else if (state_tick && timer != '1) begin
      next_timer = timer + TW'(1);
    end
  end

  // Discharge rises on trough timeout, falls on flag or peak loss; see [R13]
  always_comb begin
    next_discharge = discharge;
    if (state == ST_TROUGH && next_state == ST_FAULT) begin
      next_discharge = 1'b1;
    end else if (flags.above_65pct_flag || !flags.peak_level_ok || next_state != ST_FAULT) begin
      next_discharge = 1'b0;
    end
  end

  // Output decoded from the state, gated by start-up confirmation; see [R18] [R16]
  always_comb begin
    next_started = started | peak_confirmed;
    next_good    = (next_state == ST_CREST || next_state == ST_TROUGH) && next_started; // see [R1] [R9]
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state             <= ST_RESET;
      timer             <= '0;
      discharge         <= 1'b0;
      started           <= 1'b0;
      mains_good_out    <= 1'b0;
      discharge_req_out <= 1'b0;
    end else begin
      state             <= next_state;
      timer             <= next_timer;
      discharge         <= next_discharge;
      started           <= next_started;
      mains_good_out    <= next_good;
      discharge_req_out <= next_discharge;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  chk_low_in_init: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (state == ST_RESET || state == ST_INIT) |-> !mains_good_out) // see [R1]
    else $error("mains good high in reset or init");

  chk_init_to_settle: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (state == ST_INIT && state_tick && flags.peak_level_ok && !hold_reset) |=> state == ST_SETTLE) // see [R2]
    else $error("init did not move to settle");

  chk_init_timeout: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (state == ST_INIT && state_tick && !flags.peak_level_ok && !hold_reset && timer == TW'(INIT_TICKS - 1))
    |=> state == ST_LOW) // see [R3]
    else $error("init timeout did not reach low level");

  chk_settle_early: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (state == ST_SETTLE && timer < TW'(SETTLE_MIN)) |=> state != ST_CREST) // see [R4]
    else $error("crest reached before settle minimum");

  chk_settle_loss: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (state == ST_SETTLE && state_tick && !flags.peak_level_ok && !hold_reset) |=> state == ST_LOW) // see [R6]
    else $error("settle did not drop to low level");

  chk_crest_no_fault: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (state == ST_CREST) |=> (state != ST_FAULT && state != ST_LOW)) // see [R9] [R10]
    else $error("mains off judged from crest");

  chk_trough_timeout: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (state == ST_TROUGH && $past(state) == ST_TROUGH) |-> timer < TW'(TROUGH_TICKS)) // see [R8]
    else $error("trough outlived its window");

  chk_discharge_src: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    $rose(discharge) |-> ($past(state) == ST_TROUGH && state == ST_FAULT)) // see [R13]
    else $error("discharge raised outside trough timeout");

  chk_fault_exit: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (state == ST_FAULT && state_tick && !hold_reset && flags.peak_level_ok && flags.above_65pct_flag)
    |=> ##1 mains_good_out == started) // see [R11] [R18]
    else $error("fault recovery did not raise output");

endmodule

// *** sim/mains_sense_model.sv ***
// Purpose: Comparator pair that the presence judge listens to
// Assumes: Bench sets the wanted levels just after a rising edge
// Notes:   Levels only; analog settling and hysteresis are not modelled
`timescale 1ns/100ps
module mains_sense_model (
  // Clock
  input  wire logic sys_clk_in,
  // Wanted comparator levels
  input  wire logic want_above_in,
  input  wire logic want_peak_in,
  // Comparator outputs
  output logic      above_65pct_out,
  output logic      peak_level_ok_out
);
  // Known levels from time zero
  initial begin
    above_65pct_out   = 1'b0;
    peak_level_ok_out = 1'b0;
  end

  // Move on the falling edge so the judge never samples mid-change
  always @(negedge sys_clk_in) begin
    above_65pct_out   <= want_above_in;
    peak_level_ok_out <= want_peak_in;
  end
endmodule

// *** sim/testbench.sv ***
// Purpose: Self-checking bench for the mains presence judge
// Assumes: Short window parameters; a tick model tracks the judge
// Notes:   Compares only where the model is stable for half a tick of slack
`timescale 1ns/100ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_errors++; $display("unexpected at %0t: %s", $time, what); end end
module testbench;
  import ac_presence_pkg::*;
  // ****************************************
  // Settings and signals
  // ****************************************
  localparam int TICK   = 3200;
  localparam int N_INIT = 4;
  localparam int N_SMIN = 4;
  localparam int N_SMAX = 8;
  localparam int N_TR   = 3;
  localparam int ARM    = 24;
  logic         sys_clk_in = 1'b0;
  logic         rst_in     = 1'b1;
  logic         want_above = 1'b0;
  logic         want_peak  = 1'b0;
  logic         above_65pct_in;
  logic         peak_level_ok_in;
  logic         mains_good_out;
  logic         discharge_req_out;
  logic [31:0]  seed = 32'h4F7CD143;
  int           n_errors = 0;
  int           n_checks = 0;
  judge_state_t st = ST_INIT;
  int           tm = 0;
  int           pc = 0;
  logic         armed = 1'b0;
  logic         dis = 1'b0;

  always #20 sys_clk_in = ~sys_clk_in;

  mains_sense_model sense (
    .sys_clk_in        (sys_clk_in),
    .want_above_in     (want_above),
    .want_peak_in      (want_peak),
    .above_65pct_out   (above_65pct_in),
    .peak_level_ok_out (peak_level_ok_in)
  );

  ac_input_presence_fsm #(
    .INIT_TICKS   (N_INIT),
    .SETTLE_MIN   (N_SMIN),
    .SETTLE_MAX   (N_SMAX),
    .TROUGH_TICKS (N_TR)
  ) uut (
    .sys_clk_in        (sys_clk_in),
    .rst_in            (rst_in),
    .above_65pct_in    (above_65pct_in),
    .peak_level_ok_in  (peak_level_ok_in),
    .mains_good_out    (mains_good_out),
    .discharge_req_out (discharge_req_out)
  );

  // ****************************************
  // Helpers
  // ****************************************
  // Xorshift source for the change jitter
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // One state tick of the reference judge
  task automatic model_tick();
    judge_state_t nx;
    nx = st;
    pc = want_peak ? pc + 1 : 0;
    if (pc >= ARM) armed = 1'b1;
    case (st)
      ST_INIT:   if (want_peak) nx = ST_SETTLE; else if (tm == N_INIT - 1) nx = ST_LOW;
      ST_SETTLE: begin
        if (!want_peak) nx = ST_LOW;
        else if (want_above && tm >= N_SMIN) nx = ST_CREST;
        else if (tm == N_SMAX - 1) nx = ST_FAULT;
      end
      ST_CREST:  if (!want_above) nx = ST_TROUGH;
      ST_TROUGH: if (want_above) nx = ST_CREST; else if (tm == N_TR - 1) nx = ST_FAULT;
      ST_LOW:    if (want_peak) nx = ST_SETTLE;
      ST_FAULT:  if (!want_peak) nx = ST_LOW; else if (want_above) nx = ST_CREST;
      default:   nx = ST_INIT;
    endcase
    if (st == ST_TROUGH && nx == ST_FAULT) dis = 1'b1;
    else if (nx != ST_FAULT || want_above || !want_peak) dis = 1'b0;
    tm = (nx == st) ? tm + 1 : 0;
    st = nx;
  endtask

  // Apply levels, let n ticks pass, then compare both outputs
  task automatic run(input logic a, input logic p, input int n, input string what);
    int j;
    j = int'(rnd() % 90);
    repeat (j) @(posedge sys_clk_in);
    want_above <= a;
    want_peak  <= p;
    for (int i = 0; i < n; i++) begin
      model_tick();
      repeat (TICK) @(posedge sys_clk_in);
    end
    // Half a tick of slack covers filter and tick phase
    repeat (TICK / 2) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    `CHK(mains_good_out, armed && (st == ST_CREST || st == ST_TROUGH))
    `CHK(discharge_req_out, dis)
    $display("done %s", what);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    string what;
    what = "reset";
    repeat (5) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    rst_in = 1'b0;
    `CHK(mains_good_out, 1'b0)
    `CHK(discharge_req_out, 1'b0)
    run(1'b0, 1'b0, 8, "no peak in init");
    run(1'b1, 1'b1, 2, "early crest in settle");
    run(1'b0, 1'b1, 8, "settle window expiry");
    run(1'b1, 1'b1, 2, "crest before confirm");
    run(1'b1, 1'b1, 13, "crest holds");
    run(1'b0, 1'b1, 2, "trough inside window");
    run(1'b1, 1'b1, 2, "trough back to crest");
    run(1'b0, 1'b1, 6, "trough timeout");
    run(1'b1, 1'b1, 2, "fault back to crest");
    run(1'b0, 1'b1, 6, "second trough timeout");
    run(1'b0, 1'b0, 2, "peak lost in fault");
    run(1'b0, 1'b1, 6, "low level to settle");
    run(1'b1, 1'b1, 2, "settle to crest");
    report_and_stop();
  end

  // Watchdog well beyond the planned 61 ticks, so jitter and slack never trip it
  initial begin
    repeat (90 * TICK) @(posedge sys_clk_in);
    n_errors++;
    $display("unexpected at %0t: watchdog", $time);
    report_and_stop();
  end
endmodule
